// ==== design/pcie_rc_err_consts.vh ====
// constants for the pcie root-complex error status and ack timer block
`ifndef PCIE_RC_ERR_CONSTS_VH
`define PCIE_RC_ERR_CONSTS_VH
`define CPL_STS_SC 3'h0
`define CPL_STS_UR 3'h1
`define CPL_STS_CA 3'h4
`define LOG_STS_HI 23
`define LOG_STS_LO 21
`define RTL_LIM_W 16
`define RPL_LIM_W 16
`define RTL_LIM_RST 16'h0000
`define RPL_LIM_RST 16'h0000
`define HDR_WORDS 4
`define HDR_IDX_W 2
`define HDR_FIRST_WORD 2'h0
`define HDR_STS_WORD 2'h1
`define HDR_LAST_WORD 2'h3
`endif

// ==== design/header_log_mem.v ====
// four-word error header log storage with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "pcie_rc_err_consts.vh"
module header_log_mem (
  // clock
  input wire clk_sys,
  // write side
  input wire wrEn,
  input wire [`HDR_IDX_W-1:0] wrIdx,
  input wire [31:0] wrData,
  // read side
  input wire [`HDR_IDX_W-1:0] rdIdx,
  output reg [31:0] rdData
);
  reg [31:0] mem [0:`HDR_WORDS-1];

  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
    rdData <= mem[rdIdx];
  end
endmodule // header_log_mem
`default_nettype wire

// ==== design/pcie_rc_error_status_ack_timer.v ====
// pcie root-complex completion error capture and ack/replay timer register
// What this block does
// - Intended: unsupported-request completion sets master-abort and secondary unsupported flags.
// - Intended: completer-abort completion sets target-abort and secondary completer-abort flags.
// - Affected silicon leaves all four abort flags unchanged on these completions.
// - Erroneous completion header is logged; status sits in word one bits 23:21.
// - Logged status reads 001b for unsupported request, 100b for completer abort.
// - Two timer limit fields are written separately; writing one keeps the other.
// - Affected silicon in Gen2: writing one timer field corrupts the other too.
`timescale 1ns/1ns
`default_nettype none
`include "pcie_rc_err_consts.vh"
module pcie_rc_error_status_ack_timer (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // configuration
  input wire erratumMode,
  input wire linkGen2,
  // received completion header, one word per cycle
  input wire cplValid,
  input wire cplFirst,
  input wire [31:0] cplWord,
  // error header log readout
  input wire [`HDR_IDX_W-1:0] logRdIdx,
  output wire [31:0] logRdData,
  output reg errLogged,
  output reg [2:0] loggedStatus,
  // primary and secondary abort flags, write-one-to-clear
  input wire [3:0] abortFlagClr,
  output reg rcvdMasterAbort,
  output reg rcvdTargetAbort,
  output reg secondary_rcvd_unsupported_flag,
  output reg secondary_rcvd_completer_abort_flag,
  // ack replay timer register
  input wire rttWrEn,
  input wire [`RTL_LIM_W-1:0] rttWrData,
  input wire rplWrEn,
  input wire [`RPL_LIM_W-1:0] rplWrData,
  output reg [`RTL_LIM_W-1:0] round_trip_latency_limit,
  output reg [`RPL_LIM_W-1:0] replay_time_limit
);
  // header capture states
  localparam [1:0] ST_WATCH = 2'h0;
  localparam [1:0] ST_COPY = 2'h1;
  localparam [1:0] ST_WORD0 = 2'h2;

  reg [1:0] capState_reg;
  reg [1:0] capState_next;
  reg [`HDR_IDX_W-1:0] wordIdx_reg;
  reg [31:0] hdrWord0_reg;
  reg [2:0] curStatus_reg;
  wire [`HDR_IDX_W-1:0] curIdx;
  wire firstWord;
  wire lastWord;
  wire isErrCpl;
  wire copyWord;
  wire flushWord0;
  wire logWrEn;
  wire [`HDR_IDX_W-1:0] logWrIdx;
  wire [31:0] logWrData;
  wire isUr;
  wire isCa;
  wire [2:0] word1Status;

  // word index restarts on cplFirst, else counts up per valid word
  assign curIdx = cplFirst ? {`HDR_IDX_W{1'b0}} : wordIdx_reg;
  assign firstWord = cplValid && (curIdx == `HDR_FIRST_WORD);
  assign lastWord = cplValid && (curIdx == `HDR_LAST_WORD);
  // completion status lives in word one of the header
  assign word1Status = cplWord[`LOG_STS_HI:`LOG_STS_LO];
  assign isUr = (word1Status == `CPL_STS_UR);
  assign isCa = (word1Status == `CPL_STS_CA);
  assign isErrCpl = cplValid && (curIdx == `HDR_STS_WORD) && (isUr || isCa);

  // word one decides; words two and three then go straight in
  assign copyWord = cplValid && (capState_reg == ST_COPY) &&
    (curIdx != `HDR_FIRST_WORD);
  // word zero was held back and is written once the header is whole
  assign flushWord0 = (capState_reg == ST_WORD0);
  assign logWrEn = isErrCpl || copyWord || flushWord0;
  assign logWrIdx = flushWord0 ? `HDR_FIRST_WORD : curIdx;
  assign logWrData = flushWord0 ? hdrWord0_reg : cplWord;

  // log storage, registered read data
  header_log_mem uLog (
    .clk_sys(clk_sys),
    .wrEn(logWrEn),
    .wrIdx(logWrIdx),
    .wrData(logWrData),
    .rdIdx(logRdIdx),
    .rdData(logRdData)
  );

  // word index and the held word zero
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wordIdx_reg <= {`HDR_IDX_W{1'b0}};
      hdrWord0_reg <= 32'h0;
    end else if (cplValid) begin
      wordIdx_reg <= curIdx + 2'h1;
      if (firstWord) begin
        hdrWord0_reg <= cplWord;
      end
    end
  end

  // capture sequence: watch word one, copy two and three, then word zero
  always @* begin
    capState_next = capState_reg;
    case (capState_reg)
      ST_WATCH: begin
        if (isErrCpl) begin
          capState_next = ST_COPY;
        end
      end
      ST_COPY: begin
        if (firstWord) begin
          // header cut short: the partial capture is dropped
          capState_next = ST_WATCH;
        end else if (lastWord) begin
          capState_next = ST_WORD0;
        end
      end
      ST_WORD0: begin
        capState_next = ST_WATCH;
      end
      default: begin
        capState_next = ST_WATCH;
      end
    endcase
  end

  // capture state and the logged status
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      capState_reg <= ST_WATCH;
      curStatus_reg <= 3'h0;
      errLogged <= 1'b0;
      loggedStatus <= 3'h0;
    end else begin
      capState_reg <= capState_next;
      if (isErrCpl) begin
        curStatus_reg <= word1Status;
      end
      // pulse once all four words stand in the log
      errLogged <= flushWord0;
      if (flushWord0) begin
        loggedStatus <= curStatus_reg;
      end
    end
  end

  // abort flags: intended behaviour unless the silicon deviation is modelled
  wire setUr;
  wire setCa;

  wire rcvdMasterAbort_next;
  wire rcvdTargetAbort_next;
  wire secondary_rcvd_unsupported_flag_next;
  wire secondary_rcvd_completer_abort_flag_next;
  assign setUr = isErrCpl && isUr && !erratumMode;
  assign setCa = isErrCpl && isCa && !erratumMode;

  // set wins over a clear in the same cycle
  assign rcvdMasterAbort_next = setUr | (rcvdMasterAbort & ~abortFlagClr[0]);
  assign secondary_rcvd_unsupported_flag_next = setUr |
    (secondary_rcvd_unsupported_flag & ~abortFlagClr[1]);
  assign rcvdTargetAbort_next = setCa | (rcvdTargetAbort & ~abortFlagClr[2]);
  assign secondary_rcvd_completer_abort_flag_next = setCa |
    (secondary_rcvd_completer_abort_flag & ~abortFlagClr[3]);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rcvdMasterAbort <= 1'b0;
      rcvdTargetAbort <= 1'b0;
      secondary_rcvd_unsupported_flag <= 1'b0;
      secondary_rcvd_completer_abort_flag <= 1'b0;
    end else begin
      rcvdMasterAbort <= rcvdMasterAbort_next;
      rcvdTargetAbort <= rcvdTargetAbort_next;
      secondary_rcvd_unsupported_flag <= secondary_rcvd_unsupported_flag_next;
      secondary_rcvd_completer_abort_flag <= secondary_rcvd_completer_abort_flag_next;
    end
  end

  // ack replay timer register
  wire corrupt;
  reg [`RTL_LIM_W-1:0] round_trip_latency_limit_next;
  reg [`RPL_LIM_W-1:0] replay_time_limit_next;
  assign corrupt = erratumMode && linkGen2;

  // both enables at once: each field takes its own data
  always @* begin
    round_trip_latency_limit_next = round_trip_latency_limit;
    replay_time_limit_next = replay_time_limit;
    if (rttWrEn) begin
      round_trip_latency_limit_next = rttWrData;
    end else if (rplWrEn && corrupt) begin
      // gen2 silicon: the write spills into the field left alone
      round_trip_latency_limit_next = rplWrData;
    end
    if (rplWrEn) begin
      replay_time_limit_next = rplWrData;
    end else if (rttWrEn && corrupt) begin
      replay_time_limit_next = rttWrData;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      round_trip_latency_limit <= `RTL_LIM_RST;
      replay_time_limit <= `RPL_LIM_RST;
    end else begin
      round_trip_latency_limit <= round_trip_latency_limit_next;
      replay_time_limit <= replay_time_limit_next;
    end
  end
endmodule // pcie_rc_error_status_ack_timer
`default_nettype wire

// ==== tb/completer_model.sv ====
// completer answering non-posted requests with four-word completion headers
`timescale 1ns/1ns
`default_nettype none
module completer_model (
  // request and header
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [2:0] sts,
  output logic cplValid,
  output logic cplFirst,
  output logic [31:0] cplWord
);
  logic [2:0] idx = 3'h4;
  initial {cplValid, cplFirst, cplWord} = 34'h0;
  always @(posedge clk_sys) begin
    idx <= go ? 3'h0 : idx + {2'h0, idx != 3'h4};
    cplValid <= idx != 3'h4;
    cplFirst <= idx == 3'h0;
    // idle word toggles every cycle
    cplWord <= idx == 3'h4 ? ~cplWord : {8'ha5, idx == 3'h1 ? sts : 3'h0, 18'h0, idx};
  end
endmodule // completer_model
`default_nettype wire

// ==== tb/pcie_rc_error_status_ack_timer_properties.sv ====
// checker for the completion error and timer block
`timescale 1ns/1ns
`default_nettype none
`include "pcie_rc_err_consts.vh"
module pcie_rc_error_status_ack_timer_properties (
  // watched ports
  input wire logic clk_sys, rst_n, erratumMode, linkGen2, errLogged, rttWrEn, rplWrEn,
  input wire logic rcvdMasterAbort, rcvdTargetAbort, secondary_rcvd_unsupported_flag,
  input wire logic secondary_rcvd_completer_abort_flag,
  input wire logic [2:0] loggedStatus,
  input wire logic [`RTL_LIM_W-1:0] rttWrData, round_trip_latency_limit,
  input wire logic [`RPL_LIM_W-1:0] rplWrData, replay_time_limit
);
  wire logic [3:0] f = {rcvdMasterAbort, secondary_rcvd_unsupported_flag, rcvdTargetAbort,
    secondary_rcvd_completer_abort_flag};
  wire logic bug = erratumMode && linkGen2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_ur_flags_set: assert property
    (errLogged && loggedStatus == 3'h1 && !erratumMode |-> f[3:2] == 2'h3) else $error("ur");
  chk_ca_flags_set: assert property
    (errLogged && loggedStatus == 3'h4 && !erratumMode |-> f[1:0] == 2'h3) else $error("ca");
  chk_flags_stay_low: assert property
    (erratumMode |=> (f & ~$past(f)) == 4'h0) else $error("flag rose");
  chk_log_codes: assert property
    (errLogged |-> loggedStatus == 3'h1 || loggedStatus == 3'h4) else $error("code");
  chk_rtt_write: assert property
    (rttWrEn |=> round_trip_latency_limit == $past(rttWrData)) else $error("rtt");
  chk_rtt_kept: assert property
    (rplWrEn && !rttWrEn && !bug |=> $stable(round_trip_latency_limit)) else $error("kept");
  chk_gen2_copy: assert property
    (bug && rttWrEn && !rplWrEn |=> replay_time_limit == $past(rttWrData)) else $error("copy");
endmodule // pcie_rc_error_status_ack_timer_properties
bind pcie_rc_error_status_ack_timer pcie_rc_error_status_ack_timer_properties chk (.*);
`default_nettype wire

// ==== tb/test_pcie_rc_error_status_ack_timer.sv ====
// self-checking bench for the completion error and timer block
`timescale 1ns/1ns
`default_nettype none
module test_pcie_rc_error_status_ack_timer;
  logic clk_sys = 0, rst_n = 0, erratumMode = 0, linkGen2 = 0, go = 0, rttWrEn = 0, rplWrEn = 0;
  logic [2:0] sts = 3'h0;
  logic [3:0] abortFlagClr = 4'h0;
  logic [1:0] logRdIdx = 2'h0;
  logic [15:0] rttWrData = 16'h0, rplWrData = 16'h0;
  logic [67:0] rows [0:6];
  int errors = 0, comparisons = 0, cycles = 0;
  wire cplValid, cplFirst, errLogged, ma, ta, su, sc;
  wire [2:0] loggedStatus;
  wire [15:0] rtt, rpl;
  wire [31:0] cplWord, logRdData;
  completer_model partner (.clk_sys, .go, .sts, .cplValid, .cplFirst, .cplWord);
  pcie_rc_error_status_ack_timer dut (.clk_sys, .rst_n, .erratumMode, .linkGen2, .cplValid,
    .cplFirst, .cplWord, .logRdIdx, .logRdData, .errLogged, .loggedStatus, .abortFlagClr,
    .rcvdMasterAbort(ma), .rcvdTargetAbort(ta), .secondary_rcvd_unsupported_flag(su),
    .secondary_rcvd_completer_abort_flag(sc), .rttWrEn, .rttWrData, .rplWrEn, .rplWrData,
    .round_trip_latency_limit(rtt), .replay_time_limit(rpl));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      give_verdict();
    end
  end
  task check(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cpl(input logic em, input logic [2:0] s, input logic [3:0] fl, input logic [2:0] lg);
    @(posedge clk_sys) {erratumMode, sts, go} <= {em, s, 1'b1};
    @(posedge clk_sys) go <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 check(errLogged, s == 3'h1 || s == 3'h4);
    repeat (3) @(posedge clk_sys);
    #1 check({ma, su, ta, sc, errLogged}, {fl, 1'b0});
    check(loggedStatus, lg);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys) logRdIdx <= k[1:0];
      @(posedge clk_sys) #1 check(logRdData, {8'ha5, k == 1 ? lg : 3'h0, 18'h0, k[2:0]});
    end
  endtask
  task give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    // mode and enables, write data, expected limits
    rows = '{68'h2_1111_0000_1111_0000, 68'h1_0000_2222_1111_2222, 68'h6_3333_0000_3333_2222,
      68'h9_0000_4444_3333_4444, 68'he_5555_0000_5555_5555, 68'hf_6666_7777_6666_7777,
      68'hd_0000_8888_8888_8888};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 check({ma, su, ta, sc, errLogged, loggedStatus}, 32'h0);
    check({rtt, rpl}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys) {erratumMode, linkGen2, rttWrEn, rplWrEn, rttWrData, rplWrData}
        <= rows[i][67:32];
      @(posedge clk_sys) {rttWrEn, rplWrEn} <= 2'h0;
      #1 check({rtt, rpl}, rows[i][31:0]);
    end
    cpl(1'b1, 3'h1, 4'h0, 3'h1);
    cpl(1'b1, 3'h4, 4'h0, 3'h4);
    cpl(1'b0, 3'h1, 4'hc, 3'h1);
    cpl(1'b0, 3'h4, 4'hf, 3'h4);
    cpl(1'b0, 3'h0, 4'hf, 3'h4);
    @(posedge clk_sys) abortFlagClr <= 4'hf;
    @(posedge clk_sys) abortFlagClr <= 4'h0;
    #1 check({ma, su, ta, sc}, 32'h0);
    @(posedge clk_sys) rst_n <= 1'b0;
    @(posedge clk_sys) rst_n <= 1'b1;
    #1 check({rtt, rpl}, 32'h0);
    check(loggedStatus, 3'h0);
    give_verdict();
  end
endmodule // test_pcie_rc_error_status_ack_timer
`default_nettype wire
